// File: verilog/can_txq_pkg.sv
/*
 Constants, register map and carrier types for the CAN transmit FIFO/queue manager.
 Assumes a 12-bit APB byte address and at most 32 transmit buffers.
*/
package can_txq_pkg;

   // ------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------
   localparam logic [11:0] ADDR_BUF_CFG = 12'h0C0;
   localparam logic [11:0] ADDR_FQ_STATUS = 12'h0C4;
   localparam logic [11:0] ADDR_ELEM_CFG = 12'h0C8;
   localparam logic [11:0] ADDR_REQ_PEND = 12'h0CC;
   localparam logic [11:0] ADDR_ADD_REQ = 12'h0D0;
   localparam logic [11:0] ADDR_CANCEL_REQ = 12'h0D4;
   localparam logic [11:0] ADDR_TX_OCCURRED = 12'h0D8;
   localparam logic [11:0] ADDR_CANCEL_FIN = 12'h0DC;
   localparam logic [11:0] ADDR_DONE_IE = 12'h0E0;
   localparam logic [11:0] ADDR_CANCEL_IE = 12'h0E4;
   localparam logic [11:0] ADDR_IRQ_STATUS = 12'h0E8;
   localparam logic [11:0] ADDR_IRQ_MASK = 12'h0EC;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int START_ADDR_LSB = 0;
   localparam int DED_COUNT_LSB = 16;
   localparam int FQ_SIZE_LSB = 24;
   localparam int FQ_SELECT_BIT = 30;
   localparam int FREE_LSB = 0;
   localparam int GET_LSB = 8;
   localparam int PUT_LSB = 16;
   localparam int FULL_BIT = 21;
   localparam int IRQ_DONE_BIT = 0;
   localparam int IRQ_CANCEL_BIT = 1;
   localparam int APB_WAIT_CYCLES = 1;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_BUSY = 2'b10} txFsm_t;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } apbReq_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } apbResp_t;

   typedef struct packed {
      logic start;
      logic [4:0] index;
      logic [15:0] addr;
      logic cancel;
   } txReq_t;

   typedef struct packed {
      logic done;
      logic abort;
   } txResp_t;

   typedef struct packed {
      txFsm_t fsm;
      logic [15:0] startAddr;
      logic [5:0] dedCount;
      logic [5:0] fqSize;
      logic fqSelect;
      logic [2:0] sizeCode;
      logic [4:0] getIdx;
      logic [4:0] putIdx;
      logic full;
      logic [31:0] pending;
      logic [31:0] cancelWait;
      logic [31:0] occurred;
      logic [31:0] cancelFin;
      logic [31:0] doneIe;
      logic [31:0] cancelIe;
      logic [1:0] irqStatus;
      logic [1:0] irqMask;
      txReq_t tx;
      apbResp_t apb;
      logic irq;
   } state_t;

   localparam state_t STATE_RESET = '{fsm: TX_IDLE, default: '0};

endpackage

// File: verilog/can_tx_fifo_queue_manager.sv
/*
 Transmit buffer manager of a CAN controller: FIFO or priority queue of
 transmit buffers, APB register file, element addressing and interrupt.
 Assumes a protocol engine that answers each start pulse with one done or
 abort pulse, and identifiers of all buffers presented on bufferIds.
*/
// Decided for this implementation: register access over APB.
`timescale 1ns/100ps

module can_tx_fifo_queue_manager #(
   parameter int IdWidth = 29
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire can_txq_pkg::apbReq_t apbIn,
   output can_txq_pkg::apbResp_t apbOut,
   output can_txq_pkg::txReq_t txReq,
   input wire can_txq_pkg::txResp_t txResp,
   input wire logic [31:0][IdWidth-1:0] bufferIds,
   output logic irq
);

   // ------------------------------------------------------------
   // Helper functions
   // ------------------------------------------------------------
   function automatic logic [31:0] regionMask(logic [5:0] lo, logic [5:0] sz);
      logic [31:0] m;
      m = '0;
      for (int i = 0; i < 32; i++) begin
         if ((7'(i) >= {1'b0, lo}) && (7'(i) < ({1'b0, lo} + {1'b0, sz}))) begin
            m[i] = 1'b1;
         end
      end
      return m;
   endfunction

   // Cyclic step inside the FIFO/queue region; a zero size stays put.
   function automatic logic [4:0] wrapStep(logic [4:0] idx, logic [6:0] n, logic [5:0] lo,
                                           logic [5:0] sz);
      logic [6:0] off;
      logic [6:0] r;
      off = 7'(idx) - {1'b0, lo};
      r = 7'(idx);
      if (sz != 6'h00) begin
         r = ((off + n) % {1'b0, sz}) + {1'b0, lo};
      end
      return r[4:0];
   endfunction

   // Next buffer after start whose bit equals want; bit 5 flags a hit.
   function automatic logic [5:0] nextScan(logic [31:0] vec, logic [4:0] start, logic [5:0] lo,
                                           logic [5:0] sz, logic want);
      logic found;
      logic [4:0] hit;
      logic [4:0] c;
      found = 1'b0;
      hit = start;
      c = start;
      for (int k = 1; k <= 32; k++) begin
         c = wrapStep(start, 7'(k), lo, sz);
         if (!found && (7'(k) <= {1'b0, sz}) && (vec[c] == want)) begin
            found = 1'b1;
            hit = c;
         end
      end
      return {found, hit};
   endfunction

   function automatic logic [4:0] elemWords(logic [2:0] code);
      logic [4:0] w;
      case (code)
         3'h0: w = 5'h04;
         3'h1: w = 5'h05;
         3'h2: w = 5'h06;
         3'h3: w = 5'h07;
         3'h4: w = 5'h08;
         3'h5: w = 5'h0A;
         3'h6: w = 5'h0E;
         3'h7: w = 5'h12;
         default: w = 5'h04;
      endcase
      return w;
   endfunction

   function automatic logic [5:0] popCount(logic [31:0] v);
      logic [5:0] c;
      c = '0;
      for (int i = 0; i < 32; i++) begin
         c = c + {5'h00, v[i]};
      end
      return c;
   endfunction

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   can_txq_pkg::state_t stQ;
   can_txq_pkg::state_t stD;

   logic [31:0] mask;
   logic [5:0] freeLevel;
   logic fullView;
   logic [5:0] pendCount;
   logic [5:0] putDist;

   // ------------------------------------------------------------
   // Free level and full view
   // ------------------------------------------------------------
   // The free level is derived, not stored, so it can never drift from the FIFO indices or the queue's pending bits.
   always_comb begin
      mask = regionMask(stQ.dedCount, stQ.fqSize);
      pendCount = popCount(stQ.pending & mask);
      putDist = 6'(stQ.putIdx) - 6'(stQ.getIdx);
      freeLevel = stQ.fqSize - pendCount;
      fullView = (freeLevel == 6'h00);
      if (!stQ.fqSelect) begin
         if (stQ.full) begin
            freeLevel = 6'h00;
         end else if (stQ.putIdx >= stQ.getIdx) begin
            freeLevel = stQ.fqSize - putDist;
         end else begin
            freeLevel = 6'(stQ.getIdx) - 6'(stQ.putIdx);
         end
         fullView = stQ.full;
      end
   end

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      logic setup;
      logic access;
      logic [31:0] rdata;
      logic [31:0] addBits;
      logic [31:0] cancelBits;
      logic [5:0] scan;
      logic [5:0] nAdd;
      logic [4:0] best;
      logic bestOk;
      logic [IdWidth-1:0] bestId;
      logic [31:0] candidates;
      logic [1:0] irqSet;
      logic [15:0] offset;
      setup = apbIn.psel && !apbIn.penable;
      access = apbIn.psel && apbIn.penable && stQ.apb.pready;
      rdata = '0;
      addBits = '0;
      cancelBits = '0;
      scan = '0;
      nAdd = '0;
      best = '0;
      bestOk = 1'b0;
      bestId = '0;
      candidates = '0;
      irqSet = '0;
      offset = '0;
      stD = stQ;
      stD.tx.start = 1'b0;

      // ---------------------------------------------------------
      // Register reads
      // ---------------------------------------------------------
      // Register read data is captured in the setup cycle, so pready is high in the first access cycle
      // with no wait state, and every bus output stays on a flip-flop.
      if (setup) begin
         stD.apb.pready = 1'b1;
         stD.apb.pslverr = 1'b0;
         case (apbIn.paddr)
            can_txq_pkg::ADDR_BUF_CFG: begin
               rdata[can_txq_pkg::START_ADDR_LSB +: 16] = stQ.startAddr;
               rdata[can_txq_pkg::DED_COUNT_LSB +: 6] = stQ.dedCount;
               rdata[can_txq_pkg::FQ_SIZE_LSB +: 6] = stQ.fqSize;
               rdata[can_txq_pkg::FQ_SELECT_BIT] = stQ.fqSelect;
            end
            can_txq_pkg::ADDR_FQ_STATUS: begin
               rdata[can_txq_pkg::FREE_LSB +: 6] = freeLevel;
               rdata[can_txq_pkg::GET_LSB +: 5] = stQ.getIdx;
               rdata[can_txq_pkg::PUT_LSB +: 5] = stQ.putIdx;
               rdata[can_txq_pkg::FULL_BIT] = fullView;
            end
            can_txq_pkg::ADDR_ELEM_CFG: rdata[2:0] = stQ.sizeCode;
            can_txq_pkg::ADDR_REQ_PEND: rdata = stQ.pending;
            can_txq_pkg::ADDR_ADD_REQ: rdata = '0;
            can_txq_pkg::ADDR_CANCEL_REQ: rdata = stQ.cancelWait;
            can_txq_pkg::ADDR_TX_OCCURRED: rdata = stQ.occurred;
            can_txq_pkg::ADDR_CANCEL_FIN: rdata = stQ.cancelFin;
            can_txq_pkg::ADDR_DONE_IE: rdata = stQ.doneIe;
            can_txq_pkg::ADDR_CANCEL_IE: rdata = stQ.cancelIe;
            can_txq_pkg::ADDR_IRQ_STATUS: rdata[1:0] = stQ.irqStatus;
            can_txq_pkg::ADDR_IRQ_MASK: rdata[1:0] = stQ.irqMask;
            default: stD.apb.pslverr = 1'b1;
         endcase
         stD.apb.prdata = rdata;
      end

      if (access) begin
         stD.apb.pready = 1'b0;
         stD.apb.pslverr = 1'b0;
      end

      // ---------------------------------------------------------
      // Register writes
      // ---------------------------------------------------------
      // Writes: errored or read-only addresses store nothing.
      if (access && apbIn.pwrite && !stQ.apb.pslverr) begin
         case (apbIn.paddr)
            can_txq_pkg::ADDR_BUF_CFG: begin
               stD.startAddr = apbIn.pwdata[can_txq_pkg::START_ADDR_LSB +: 16];
               stD.dedCount = apbIn.pwdata[can_txq_pkg::DED_COUNT_LSB +: 6];
               stD.fqSize = apbIn.pwdata[can_txq_pkg::FQ_SIZE_LSB +: 6];
               stD.fqSelect = apbIn.pwdata[can_txq_pkg::FQ_SELECT_BIT];
               // A new layout restarts both indices at the region's first buffer.
               stD.getIdx = apbIn.pwdata[can_txq_pkg::DED_COUNT_LSB +: 5];
               stD.putIdx = apbIn.pwdata[can_txq_pkg::DED_COUNT_LSB +: 5];
               stD.full = 1'b0;
            end
            can_txq_pkg::ADDR_ELEM_CFG: stD.sizeCode = apbIn.pwdata[2:0];
            can_txq_pkg::ADDR_ADD_REQ: addBits = apbIn.pwdata & mask & ~stQ.pending;
            can_txq_pkg::ADDR_CANCEL_REQ: cancelBits = apbIn.pwdata & stQ.pending;
            can_txq_pkg::ADDR_DONE_IE: stD.doneIe = apbIn.pwdata;
            can_txq_pkg::ADDR_CANCEL_IE: stD.cancelIe = apbIn.pwdata;
            can_txq_pkg::ADDR_IRQ_STATUS: stD.irqStatus = stQ.irqStatus & ~apbIn.pwdata[1:0];
            can_txq_pkg::ADDR_IRQ_MASK: stD.irqMask = apbIn.pwdata[1:0];
            default: stD.irqMask = stD.irqMask;
         endcase
      end

      // ---------------------------------------------------------
      // Cancellation and engine answer
      // ---------------------------------------------------------
      // Cancellation of idle buffers is immediate; the buffer on the bus waits
      // for the engine's verdict so a frame is never cut mid-flight.
      for (int i = 0; i < 32; i++) begin
         if (cancelBits[i]) begin
            if ((stQ.fsm == can_txq_pkg::TX_BUSY) && (stQ.tx.index == 5'(i))) begin
               stD.cancelWait[i] = 1'b1;
            end else begin
               stD.pending[i] = 1'b0;
               stD.cancelFin[i] = 1'b1;
               if (stQ.cancelIe[i]) begin
                  irqSet[can_txq_pkg::IRQ_CANCEL_BIT] = 1'b1;
               end
            end
         end
      end

      // Engine answer for the buffer in flight.
      stD.tx.cancel = (stQ.fsm == can_txq_pkg::TX_BUSY) && stD.cancelWait[stQ.tx.index];
      case (stQ.fsm)
         can_txq_pkg::TX_IDLE: begin
            stD.fsm = can_txq_pkg::TX_IDLE;
         end
         can_txq_pkg::TX_BUSY: begin
            if (txResp.done) begin
               stD.pending[stQ.tx.index] = 1'b0;
               stD.cancelWait[stQ.tx.index] = 1'b0;
               stD.occurred[stQ.tx.index] = 1'b1;
               if (stQ.doneIe[stQ.tx.index]) begin
                  irqSet[can_txq_pkg::IRQ_DONE_BIT] = 1'b1;
               end
               stD.fsm = can_txq_pkg::TX_IDLE;
               stD.tx.cancel = 1'b0;
            end else if (txResp.abort) begin
               // An abort without a cancel leaves the request pending for a retry.
               if (stD.cancelWait[stQ.tx.index]) begin
                  stD.pending[stQ.tx.index] = 1'b0;
                  stD.cancelWait[stQ.tx.index] = 1'b0;
                  stD.cancelFin[stQ.tx.index] = 1'b1;
                  if (stQ.cancelIe[stQ.tx.index]) begin
                     irqSet[can_txq_pkg::IRQ_CANCEL_BIT] = 1'b1;
                  end
               end
               stD.fsm = can_txq_pkg::TX_IDLE;
               stD.tx.cancel = 1'b0;
            end
         end
         default: begin
            stD.fsm = can_txq_pkg::TX_IDLE;
         end
      endcase

      // ---------------------------------------------------------
      // Index upkeep
      // ---------------------------------------------------------
      // In FIFO mode, removing the element at the get index moves get to the next pending one,
      // or onto put when the FIFO ran empty; other removals leave it alone.
      if (!stQ.fqSelect && stQ.pending[stQ.getIdx] && !stD.pending[stQ.getIdx]) begin
         scan = nextScan(stD.pending, stQ.getIdx, stQ.dedCount, stQ.fqSize, 1'b1);
         stD.getIdx = scan[5] ? scan[4:0] : stQ.putIdx;
         stD.full = 1'b0;
      end

      // Add requests.
      if (addBits != '0) begin
         stD.pending = stD.pending | addBits;
         stD.occurred = stD.occurred & ~addBits;
         stD.cancelFin = stD.cancelFin & ~addBits;
         nAdd = popCount(addBits);
         if (!stQ.fqSelect) begin
            stD.putIdx = wrapStep(stQ.putIdx, 7'(nAdd), stQ.dedCount, stQ.fqSize);
            stD.full = (stD.putIdx == stD.getIdx);
         end else begin
            scan = nextScan(stD.pending, stQ.putIdx, stQ.dedCount, stQ.fqSize, 1'b0);
            stD.putIdx = scan[5] ? scan[4:0] : stQ.putIdx;
         end
      end

      // ---------------------------------------------------------
      // Scheduler and interrupt
      // ---------------------------------------------------------
      // Scheduler: FIFO serves only the get element, which keeps written order;
      // the queue takes the lowest identifier, strict compare keeps the lowest number.
      candidates = stQ.pending & mask & ~stQ.cancelWait;
      if (!stQ.fqSelect) begin
         bestOk = candidates[stQ.getIdx];
         best = stQ.getIdx;
      end else begin
         for (int i = 0; i < 32; i++) begin
            if (candidates[i] && (!bestOk || (bufferIds[i] < bestId))) begin
               bestOk = 1'b1;
               best = 5'(i);
               bestId = bufferIds[i];
            end
         end
      end
      if ((stQ.fsm == can_txq_pkg::TX_IDLE) && bestOk && stD.pending[best]) begin
         offset = 16'(best) * 16'(elemWords(stQ.sizeCode));
         stD.tx.start = 1'b1;
         stD.tx.index = best;
         stD.tx.addr = stQ.startAddr + offset;
         stD.fsm = can_txq_pkg::TX_BUSY;
      end

      // Hardware events win over a software clear in the same cycle.
      stD.irqStatus = stD.irqStatus | irqSet;
      stD.irq = |(stD.irqStatus & stD.irqMask);
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         stQ <= can_txq_pkg::STATE_RESET;
      end else begin
         stQ <= stD;
      end
   end

   assign apbOut = stQ.apb;
   assign txReq = stQ.tx;
   assign irq = stQ.irq;

endmodule

// File: bench/can_txq_properties.sv
/*
 Port checker for the CAN transmit FIFO/queue manager.
 Assumes a bind onto the top module, one clock and a synchronous reset.
*/
`timescale 1ns/100ps
module can_txq_properties #(
   parameter int IdWidth = 29
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire can_txq_pkg::apbReq_t apbIn,
   input wire can_txq_pkg::apbResp_t apbOut,
   input wire can_txq_pkg::txReq_t txReq,
   input wire can_txq_pkg::txResp_t txResp,
   input wire logic [31:0][IdWidth-1:0] bufferIds,
   input wire logic irq
);
   // --------------------------------
   // Frame tracking and properties
   // --------------------------------
   logic inFlight_q;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);
   // A frame is open from its start pulse to the engine's done or abort.
   always_ff @(posedge core_clk) begin
      inFlight_q <= !sys_rst && (txReq.start || (inFlight_q && !txResp.done && !txResp.abort));
   end
   sequence s_setup;
      apbIn.psel && !apbIn.penable;
   endsequence
   sequence s_finish;
      inFlight_q && (txResp.done || txResp.abort);
   endsequence
   a_ready_after_setup: assert property (s_setup |=> apbOut.pready)
      else $error("pready missing after setup");
   a_ready_one_cycle: assert property (apbOut.pready |=> !apbOut.pready)
      else $error("pready held too long");
   a_error_with_ready: assert property (apbOut.pslverr |-> apbOut.pready)
      else $error("pslverr without pready");
   a_start_when_idle: assert property (txReq.start |-> !inFlight_q)
      else $error("start while a frame is open");
   a_gap_after_finish: assert property (s_finish |=> !txReq.start)
      else $error("start too soon after finish");
   a_index_held: assert property (!txReq.start |-> $stable(txReq.index) && $stable(txReq.addr))
      else $error("index or address moved without start");
   a_cancel_in_flight: assert property (txReq.cancel |-> inFlight_q)
      else $error("cancel shown with no open frame");
   a_reset_quiet: assert property ($fell(sys_rst) |-> !irq && !txReq.start && txReq.index == 5'h00)
      else $error("outputs not cleared by reset");
endmodule

// File: bench/can_txq_engine_model.sv
/*
 Protocol engine model: answers each start with done or abort after a delay.
 Assumes delay is at least one; a pending cancel turns done into abort.
*/
`timescale 1ns/100ps
module can_txq_engine_model (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire can_txq_pkg::txReq_t txReq,
   input wire logic [7:0] delay,
   output can_txq_pkg::txResp_t txResp
);
   // --------------------------------
   // Frame timing
   // --------------------------------
   logic busy_q;
   logic [7:0] count_q;
   always_ff @(posedge core_clk) begin
      txResp <= '0;
      if (sys_rst) begin
         busy_q <= 1'b0;
         count_q <= 8'h00;
      end else if (txReq.start) begin
         busy_q <= 1'b1;
         count_q <= delay;
      end else if (busy_q && count_q > 8'h01) begin
         count_q <= count_q - 8'h01;
      end else if (busy_q) begin
         busy_q <= 1'b0;
         txResp.done <= !txReq.cancel;
         txResp.abort <= txReq.cancel;
      end
   end
endmodule

// File: bench/can_tx_fifo_queue_manager_test.sv
/*
 Self-checking bench for the CAN transmit FIFO/queue manager.
 Assumes the engine model on the far side and APB access to the registers.
*/
`timescale 1ns/100ps
module can_tx_fifo_queue_manager_test;
   // --------------------------------
   // Signals and helpers
   // --------------------------------
   localparam int IdWidth = 29;
   localparam int ElemWords[8] = '{4, 5, 6, 7, 8, 10, 14, 18};
   logic core_clk;
   logic sys_rst;
   can_txq_pkg::apbReq_t apbIn;
   can_txq_pkg::apbResp_t apbOut;
   can_txq_pkg::txReq_t txReq;
   can_txq_pkg::txResp_t txResp;
   logic [31:0][IdWidth-1:0] bufferIds;
   logic irq;
   logic [7:0] engDelay;
   logic inFlight;
   logic [64:0] note;
   logic [31:0] seed;
   int err_total;
   int checks_done;
   int cycles;
   logic [64:0] rdQ[$];
   logic [20:0] txQ[$];

   can_tx_fifo_queue_manager #(.IdWidth(IdWidth)) uut (.core_clk(core_clk), .sys_rst(sys_rst),
      .apbIn(apbIn), .apbOut(apbOut), .txReq(txReq), .txResp(txResp),
      .bufferIds(bufferIds), .irq(irq));
   can_txq_engine_model engine (.core_clk(core_clk), .sys_rst(sys_rst), .txReq(txReq),
      .delay(engDelay), .txResp(txResp));

   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end

   function logic [31:0] next_rand();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task check(input logic [63:0] seen, input logic [63:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task end_of_test;
      // Expected starts or reads that never showed up count as a mismatch.
      check(64'(txQ.size() + rdQ.size()), 64'h0);
      $display("Comparisons %0d, mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // One idle cycle follows every transfer so no signal is driven twice at one edge.
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] m,
      input logic e);
      if (!w) begin
         rdQ.push_back({m, e, d});
      end
      apbIn <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
      @(posedge core_clk);
      apbIn.penable <= 1'b1;
      @(posedge core_clk);
      while (apbOut.pready !== 1'b1) @(posedge core_clk);
      apbIn <= '0;
      @(posedge core_clk);
   endtask

   task wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, '0, 1'b0);
   endtask

   task rd(input logic [11:0] a, input logic [31:0] d, input logic [31:0] m);
      apb(1'b0, a, d, m, 1'b0);
   endtask

   task wr_irq(input logic [11:0] a, input logic [31:0] d, input logic e);
      wr(a, d);
      @(posedge core_clk);
      check(irq, e);
   endtask

   task expect_tx(input logic [4:0] i, input logic [15:0] base, input int code);
      txQ.push_back({i, base + 16'(int'(i) * ElemWords[code])});
   endtask

   task wait_idle;
      for (int i = 0; i < 3000 && (txQ.size() != 0 || inFlight); i++) @(posedge core_clk);
      repeat (3) @(posedge core_clk);
   endtask

   // --------------------------------
   // Output monitor
   // --------------------------------
   always @(posedge core_clk) begin
      cycles++;
      if (cycles > 20000) begin
         err_total++;
         end_of_test();
      end
      if (!sys_rst && apbIn.psel && apbIn.penable && apbOut.pready === 1'b1 && !apbIn.pwrite) begin
         note = rdQ.pop_front();
         check({apbOut.pslverr, apbOut.prdata & note[64:33]}, {note[32], note[31:0] & note[64:33]});
      end
      if (txReq.start === 1'b1) begin
         inFlight = 1'b1;
         check({txReq.index, txReq.addr}, txQ.pop_front());
      end else if (txResp.done || txResp.abort) begin
         inFlight = 1'b0;
      end
   end

   // --------------------------------
   // Main sequence
   // --------------------------------
   initial begin
      seed = 32'h0001043C;
      apbIn = '0;
      sys_rst = 1'b1;
      engDelay = 8'h04;
      bufferIds = '0;
      inFlight = 1'b0;
      cycles = 0;
      err_total = 0;
      checks_done = 0;
      repeat (3) @(posedge core_clk);
      sys_rst <= 1'b0;
      wr(can_txq_pkg::ADDR_FQ_STATUS, '1);
      rd(can_txq_pkg::ADDR_BUF_CFG, '0, '1);
      rd(can_txq_pkg::ADDR_FQ_STATUS, '0, '1);
      apb(1'b0, 12'h0F0, '0, '1, 1'b1);
      wr(can_txq_pkg::ADDR_BUF_CFG, 32'h04020100);
      rd(can_txq_pkg::ADDR_FQ_STATUS, 32'h00020204, '1);
      for (int k = 0; k < 8; k++) begin
         engDelay <= 8'(next_rand() % 32'h10 + 32'h1);
         wr(can_txq_pkg::ADDR_ELEM_CFG, 32'(k));
         expect_tx(5'(2 + k % 4), 16'h0100, k);
         wr(can_txq_pkg::ADDR_ADD_REQ, 32'h1 << (2 + k % 4));
         wait_idle();
      end
      wr(can_txq_pkg::ADDR_DONE_IE, 32'h8);
      wr(can_txq_pkg::ADDR_IRQ_MASK, 32'h1);
      engDelay <= 8'h28;
      expect_tx(5'h02, 16'h0100, 7);
      expect_tx(5'h03, 16'h0100, 7);
      expect_tx(5'h05, 16'h0100, 7);
      wr(can_txq_pkg::ADDR_ADD_REQ, 32'h3C);
      rd(can_txq_pkg::ADDR_FQ_STATUS, 32'h00220200, '1);
      wr(can_txq_pkg::ADDR_CANCEL_REQ, 32'h10);
      rd(can_txq_pkg::ADDR_FQ_STATUS, 32'h00220200, '1);
      wr(can_txq_pkg::ADDR_CANCEL_REQ, 32'h4);
      wait_idle();
      rd(can_txq_pkg::ADDR_FQ_STATUS, 32'h00020204, '1);
      rd(can_txq_pkg::ADDR_TX_OCCURRED, 32'h28, '1);
      rd(can_txq_pkg::ADDR_CANCEL_FIN, 32'h14, '1);
      check(irq, 1'b1);
      wr_irq(can_txq_pkg::ADDR_IRQ_MASK, 32'h0, 1'b0);
      wr_irq(can_txq_pkg::ADDR_IRQ_MASK, 32'h1, 1'b1);
      wr_irq(can_txq_pkg::ADDR_IRQ_STATUS, 32'h1, 1'b0);
      // Queue mode: buffers 2 and 3 share the lowest identifier.
      for (int i = 4; i < 32; i++) bufferIds[i] <= IdWidth'(next_rand());
      bufferIds[0] <= 29'h00000050;
      bufferIds[1] <= 29'h00000020;
      bufferIds[2] <= 29'h00000010;
      bufferIds[3] <= 29'h00000010;
      wr(can_txq_pkg::ADDR_BUF_CFG, 32'h44000200);
      wr(can_txq_pkg::ADDR_ELEM_CFG, 32'h0);
      expect_tx(5'h00, 16'h0200, 0);
      expect_tx(5'h02, 16'h0200, 0);
      expect_tx(5'h03, 16'h0200, 0);
      expect_tx(5'h01, 16'h0200, 0);
      wr(can_txq_pkg::ADDR_ADD_REQ, 32'h1);
      rd(can_txq_pkg::ADDR_FQ_STATUS, 32'h00010003, 32'h003F003F);
      wr(can_txq_pkg::ADDR_ADD_REQ, 32'hE);
      rd(can_txq_pkg::ADDR_FQ_STATUS, 32'h00200000, 32'h0020003F);
      wait_idle();
      // A reset once the queue run has gone idle must drop the layout and both indices.
      sys_rst <= 1'b1;
      repeat (3) @(posedge core_clk);
      sys_rst <= 1'b0;
      rd(can_txq_pkg::ADDR_BUF_CFG, '0, '1);
      rd(can_txq_pkg::ADDR_FQ_STATUS, '0, '1);
      end_of_test();
   end
endmodule

bind can_tx_fifo_queue_manager can_txq_properties #(.IdWidth(IdWidth)) chk (.core_clk(core_clk),
   .sys_rst(sys_rst), .apbIn(apbIn), .apbOut(apbOut), .txReq(txReq), .txResp(txResp),
   .bufferIds(bufferIds), .irq(irq));
